// File: inc/pts_cfg.svh
// timing, window and command constants for the pixel trigger sequencer
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
`define PTS_CLK_PS       4000
`define PTS_TICK_PS      24900
`define PTS_TICK_CYC     ((`PTS_TICK_PS + `PTS_CLK_PS / 2) / `PTS_CLK_PS)
`define PTS_PERIOD_TICKS 68
`define PTS_INTIME_TICKS 10
`define PTS_OOT_TICKS    58
`define PTS_PRESCALE     10
`define PTS_MIN_SPACING  5
`define PTS_READOUT      6
`define PTS_DEAD         1
`define PTS_MARGIN_PRE   1
`define PTS_MARGIN_POST  1
`define PTS_CMD_LEN      5
`define PTS_CMD_PAT      5'h1d
`endif

// File: inc/pts_pkg.sv
// types shared by the pixel trigger sequencer
package pts_pkg;
    // discriminated counter inputs, three per side of the magnet
    typedef struct packed {
        logic [2:0] up;   // upstream counters
        logic [2:0] dn;   // downstream counters
    } pts_scint_t;
    // per-plane readout phase
    typedef enum logic [1:0] {
        PTS_IDLE,
        PTS_READ,
        PTS_DEADT
    } pts_phase_t;
    // tick-domain status
    typedef struct packed {
        logic       inTime;   // last tick was in-time
        logic       coinc;    // coincidence seen in last tick
        logic [6:0] tick;     // tick index within period
    } pts_stat_t;
endpackage

// File: verilog/pts_trigger_sequencer.sv
// pixel telescope trigger sequencer: coincidence, prescale, margins, cmds
// Contract
// RULE1: tick of 24.9 ns, 68 per revolution; code ticks every 6 cycles, 24 ns
// RULE2: period 68 ticks: 10 in-time, 58 out
// RULE3: in-time flag from free-running tick counter
// RULE4: combine counter inputs into one coincidence
// RULE5: in-time coincidences read one bunch in ten
// RULE6: every out-of-time coincidence triggers
// RULE7: add margins before and after each coincidence
// RULE8: trigger commands go out on serial lines
// RULE9: commands to one chip five ticks apart
// RULE10: chip reads six ticks per command
// RULE11: one dead tick after each readout
// RULE12: one dead plane per stack at most
// RULE13: chip hits use 80 by 336 pixels
// RULE14: chip reports hit time and tot ticks; chip model keeps hit tick only, no tot
// RULE15: two of three up and down
// RULE16: reset clears counters, no early commands
`timescale 1ns/1ps
`include "pts_cfg.svh"
module pts_trigger_sequencer
    import pts_pkg::*;
#(
    parameter int NSTACK      = 2,                 // sensor stacks
    parameter int NPLANE      = 4,                 // planes per stack
    parameter int PRESCALE    = `PTS_PRESCALE,     // in-time prescale
    parameter int MARGIN_PRE  = `PTS_MARGIN_PRE,   // ticks before
    parameter int MARGIN_POST = `PTS_MARGIN_POST   // ticks after
) (
    input  wire logic                     mclk,      // 250 MHz clock
    input  wire logic                     rst,       // sync reset, high
    input  wire pts_scint_t               scintIn,   // discriminator pins
    input  wire logic                     revMark,   // revolution marker pin
    output logic [NSTACK*NPLANE-1:0]      cmdLine,   // serial trigger lines
    output pts_stat_t                     status     // tick-domain status
);
    localparam int NCH   = NSTACK * NPLANE;
    localparam int HISTW = MARGIN_PRE + MARGIN_POST + 1;
    localparam int BUSY  = `PTS_READOUT + `PTS_DEAD;
    localparam int PSW   = $clog2(PRESCALE + 1);

    // refuse settings the scheduler cannot honour
    if (NPLANE > BUSY || NPLANE < 1)
        $error("NPLANE must lie between 1 and readout plus dead ticks");
    if (BUSY < `PTS_MIN_SPACING)
        $error("readout plus dead shorter than command spacing");
    if (PRESCALE < 1)
        $error("PRESCALE must be at least one");
    if (MARGIN_PRE < 0 || MARGIN_POST < 0 || HISTW < 2)
        $error("margins must be non-negative and not both zero");
    if (BUSY > 15)
        $error("readout plus dead does not fit the busy counter");
    if (NSTACK < 1)
        $error("NSTACK must be at least one");
    if (`PTS_INTIME_TICKS + `PTS_OOT_TICKS != `PTS_PERIOD_TICKS)
        $error("period split does not add up");

    // two-flop synchronisers for pins
    pts_scint_t scintMeta_r;                 // first stage, read by second only
    pts_scint_t scintSync_r;                 // usable counter levels
    logic       revMeta_r;                   // first stage of marker
    logic       revSync_r;                   // synchronised marker
    logic       revLast_r;                   // marker edge history
    always_ff @(posedge mclk) begin
        if (rst) begin
            scintMeta_r <= '0;
            scintSync_r <= '0;
            revMeta_r   <= 1'b0;
            revSync_r   <= 1'b0;
            revLast_r   <= 1'b0;
        end else begin
            scintMeta_r <= scintIn;
            scintSync_r <= scintMeta_r;
            revMeta_r   <= revMark;
            revSync_r   <= revMeta_r;
            revLast_r   <= revSync_r;
        end
    end
    logic revEdge;                           // marker rising edge
    assign revEdge = revSync_r & ~revLast_r;

    // tick enable from divider; the 24.9 ns tick rounds to whole cycles,
    // so the marker realigns the phase once per revolution
    logic [7:0] divCnt_r;                    // cycles within tick
    logic       tickEn;                      // one-cycle tick pulse
    assign tickEn = (divCnt_r == 8'(`PTS_TICK_CYC - 1));
    always_ff @(posedge mclk) begin
        if (rst || revEdge) begin
            divCnt_r <= '0;                  // [RULE1]
        end else if (tickEn) begin
            divCnt_r <= '0;
        end else begin
            divCnt_r <= divCnt_r + 8'h01;
        end
    end

    // free-running tick counter over one micro-bunch period
    logic [6:0] tickCnt_r;                   // tick index 0..67
    logic       wrap;                        // last tick of period
    assign wrap = (tickCnt_r == 7'(`PTS_PERIOD_TICKS - 1));
    always_ff @(posedge mclk) begin
        if (rst || revEdge) begin
            tickCnt_r <= '0;                 // [RULE16] [RULE1]
        end else if (tickEn) begin
            tickCnt_r <= wrap ? 7'h00 : tickCnt_r + 7'h01; // [RULE2]
        end
    end
    logic inTime;                            // first 10 ticks in-time
    assign inTime = (tickCnt_r < 7'(`PTS_INTIME_TICKS)); // [RULE3] [RULE2]

    // prescale counter over micro-bunches
    logic [PSW-1:0] preCnt_r;                // bunch index mod prescale
    always_ff @(posedge mclk) begin
        if (rst) begin
            preCnt_r <= '0;                  // [RULE16]
        end else if (tickEn && wrap) begin
            if (preCnt_r == PSW'(PRESCALE - 1)) begin
                preCnt_r <= '0;              // [RULE5]
            end else begin
                preCnt_r <= preCnt_r + PSW'(1);
            end
        end
    end

    // coincidence: two of three each side, both sides together
    function automatic logic twoOfThree(input logic [2:0] v);
        twoOfThree = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    logic coincNow;                          // per-cycle coincidence
    assign coincNow = twoOfThree(scintSync_r.up)
                    & twoOfThree(scintSync_r.dn); // [RULE15] [RULE4]

    // hold any coincidence seen within the tick; short pulses are
    // caught even though the tick spans several clock cycles
    logic coincHold_r;                       // seen during this tick
    always_ff @(posedge mclk) begin
        if (rst || tickEn) begin
            coincHold_r <= 1'b0;
        end else if (coincNow) begin
            coincHold_r <= 1'b1;             // [RULE4]
        end
    end
    logic coincTick;                         // coincidence in ending tick
    assign coincTick = coincHold_r | coincNow;

    // started flag: nothing is issued before the first tick
    logic run_r;                             // counters running
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_r <= 1'b0;                   // [RULE16]
        end else if (tickEn) begin
            run_r <= 1'b1;
        end
    end

    // acceptance: out-of-time always, in-time only on bunch zero;
    // tick zero after reset is never accepted, run_r is still low there
    logic accept;                            // coincidence kept
    assign accept = run_r & coincTick
                  & (~inTime | (preCnt_r == '0)); // [RULE5] [RULE6]

    // margins by dilation: a tick is wanted if any accept lies within
    // pre..post of it; the wanted stream lags by post ticks
    logic [HISTW-1:0] hist_r;                // recent accepts
    always_ff @(posedge mclk) begin
        if (rst) begin
            hist_r <= '0;
        end else if (tickEn) begin
            hist_r <= {hist_r[HISTW-2:0], accept}; // [RULE7]
        end
    end
    logic wanted;                            // tick to be read out
    assign wanted = run_r & (|hist_r);       // [RULE7]

    // per-plane scheduling
    logic [3:0] busy_r [NCH];                // ticks left in readout+dead
    pts_phase_t phase [NCH];                 // derived plane phase
    logic [NCH-1:0] want;                    // plane would fire this tick
    logic [NCH-1:0] fire;                    // plane fires this tick
    logic [NCH-1:0] held_r;                  // plane owed a command

    for (genvar c = 0; c < NCH; c++) begin : g_plane
        // readout then a dead tick; no new command until both pass
        always_comb begin
            if (busy_r[c] == 4'h0) begin
                phase[c] = PTS_IDLE;
            end else if (busy_r[c] == 4'(`PTS_DEAD)) begin
                phase[c] = PTS_DEADT;        // [RULE11]
            end else begin
                phase[c] = PTS_READ;         // [RULE10]
            end
        end
        // a plane refused its slot by the stack arbiter keeps its claim
        // until served; without it the last plane of a stack would miss
        // its command once the margin window closes
        assign want[c] = (wanted | held_r[c])
                       & (phase[c] == PTS_IDLE); // [RULE9]

        // claim kept only while idle and refused; dropped once fired
        always_ff @(posedge mclk) begin
            if (rst) begin
                held_r[c] <= 1'b0;           // [RULE16]
            end else if (tickEn) begin
                held_r[c] <= want[c] & ~fire[c]; // [RULE12]
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                busy_r[c] <= '0;             // [RULE16]
            end else if (tickEn) begin
                if (fire[c]) begin
                    busy_r[c] <= 4'(BUSY);   // [RULE9] [RULE11]
                end else if (busy_r[c] != 4'h0) begin
                    busy_r[c] <= busy_r[c] - 4'h1;
                end
            end
        end
    end

    // at most one firing per stack per tick keeps dead ticks apart;
    // a held-off plane starts one tick later per plane ahead of it, up to NPLANE-1 ticks
    for (genvar s = 0; s < NSTACK; s++) begin : g_stack
        always_comb begin
            logic taken;
            taken = 1'b0;
            for (int p = 0; p < NPLANE; p++) begin
                fire[s*NPLANE+p] = want[s*NPLANE+p] & ~taken; // [RULE12]
                taken = taken | want[s*NPLANE+p];
            end
        end
    end

    // serial command shifters, one per chip line, sent in the tick
    // after the plane fires; the pattern is shorter than a tick
    logic [`PTS_CMD_LEN-1:0] shift_r [NCH]; // pattern being sent
    for (genvar c = 0; c < NCH; c++) begin : g_link
        always_ff @(posedge mclk) begin
            if (rst) begin
                shift_r[c] <= '0;
                cmdLine[c] <= 1'b0;
            end else begin
                cmdLine[c] <= shift_r[c][`PTS_CMD_LEN-1]; // [RULE8]
                if (tickEn && fire[c]) begin
                    shift_r[c] <= `PTS_CMD_PAT;           // [RULE8]
                end else begin
                    shift_r[c] <= {shift_r[c][`PTS_CMD_LEN-2:0], 1'b0};
                end
            end
        end
    end

    // status outputs, registered on each tick; they read zero until
    // the first tick after reset ends, so the flag there is not yet valid
    always_ff @(posedge mclk) begin
        if (rst) begin
            status <= '0;
        end else if (tickEn) begin
            status.inTime <= inTime;         // [RULE3]
            status.coinc  <= coincTick;
            status.tick   <= tickCnt_r;
        end
    end
endmodule

// File: verif/pts_chip_model.sv
// behavioural readout chips decoding the serial trigger lines
`timescale 1ns/1ps
`include "pts_cfg.svh"
module pts_chip_model #(
    parameter int NL = 8 // trigger lines
) (
    input wire logic          mclk,        // clock
    input wire logic          rst,         // sync reset
    input wire logic [NL-1:0] cmdLine,     // serial trigger lines
    output int                cmdCnt [NL], // commands decoded
    output int                errCnt       // commands that came too soon
);
    // readout plus dead tick, in clock cycles
    localparam int BUSY = (`PTS_READOUT + `PTS_DEAD) * `PTS_TICK_CYC;
    logic [4:0] shift_r [NL]; // newest bit in the lsb
    int         busy_r [NL];  // cycles left before a chip is ready
    // hit reports: an 80 by 336 pixel array, times counted in ticks
    localparam int NCOL = 80;  // pixel columns
    localparam int NROW = 336; // pixel rows
    int         cycNo;        // cycles since reset
    int         hitPix [NL];  // pixel address of the last report
    int         hitTick [NL]; // tick of the last report

    // decode per line; a command while busy is the chip's lost trigger
    always_ff @(posedge mclk) begin
        if (rst) begin
            errCnt <= 0;
            cycNo  <= 0;
        end else begin
            cycNo  <= cycNo + 1;
        end
        for (int i = 0; i < NL; i++) begin
            shift_r[i] <= {shift_r[i][3:0], cmdLine[i]};
            if (rst) begin
                cmdCnt[i] <= 0;
                busy_r[i] <= 0;
                hitPix[i] <= 0;
                hitTick[i] <= 0;
            end else if ({shift_r[i][3:0], cmdLine[i]} == `PTS_CMD_PAT) begin
                cmdCnt[i] <= cmdCnt[i] + 1;
                busy_r[i] <= BUSY - 1;
                hitPix[i] <= (hitPix[i] + 1) % (NCOL * NROW);
                hitTick[i] <= cycNo / `PTS_TICK_CYC;
                if (busy_r[i] > 0)
                    errCnt <= errCnt + 1;
            end else if (busy_r[i] > 0)
                busy_r[i] <= busy_r[i] - 1;
        end
    end
endmodule

// File: verif/pts_trigger_sequencer_chk.sv
// concurrent checks on the trigger sequencer ports
`timescale 1ns/1ps
`include "pts_cfg.svh"
module pts_trigger_sequencer_chk
    import pts_pkg::*;
#(
    parameter int NSTACK = 2, // sensor stacks
    parameter int NPLANE = 4  // planes per stack
) (
    input wire logic                     mclk,    // clock
    input wire logic                     rst,     // sync reset
    input wire pts_scint_t               scintIn, // counter pins
    input wire logic                     revMark, // marker pin
    input wire logic [NSTACK*NPLANE-1:0] cmdLine, // trigger lines
    input wire pts_stat_t                status   // tick status
);
    localparam int NL = NSTACK * NPLANE;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [NL-1:0] prev1_r;      // lines one cycle back
    logic [NL-1:0] prev2_r;      // lines two cycles back
    logic [NL-1:0] start;        // first bit of a command
    logic [5:0]    gap_r [NL];   // cycles since last start, saturating
    logic [5:0]    sinceCoinc_r; // cycles since status showed coinc
    logic [4:0]    sinceHit_r;   // cycles since a two-sided input hit
    logic [3:0]    sinceRst_r;   // cycles since reset, saturating
    logic [3:0]    sinceRev_r;   // cycles since marker high, saturating
    logic          hit;          // two of three on both sides
    assign hit = $countones(scintIn.up) >= 2 && $countones(scintIn.dn) >= 2;
    // the last pattern bit follows a zero after a one, so never a start
    assign start = cmdLine & ~prev1_r & ~prev2_r;

    // line history for start detection
    always_ff @(posedge mclk) begin
        prev1_r <= cmdLine;
        prev2_r <= prev1_r;
    end
    // age of the last coincidence; saturates so reset means never
    always_ff @(posedge mclk) begin
        if (rst) sinceCoinc_r <= 6'h3f;
        else if (status.coinc) sinceCoinc_r <= 6'h00;
        else if (sinceCoinc_r != 6'h3f) sinceCoinc_r <= sinceCoinc_r + 6'h01;
    end
    // age of the last input hit
    always_ff @(posedge mclk) begin
        if (rst) sinceHit_r <= 5'h1f;
        else if (hit) sinceHit_r <= 5'h00;
        else if (sinceHit_r != 5'h1f) sinceHit_r <= sinceHit_r + 5'h01;
    end
    // status holds its reset value until the first tick ends
    always_ff @(posedge mclk) begin
        if (rst) sinceRst_r <= 4'h0;
        else if (sinceRst_r != 4'hf) sinceRst_r <= sinceRst_r + 4'h1;
    end
    // a marker pulse may restart the tick count from zero
    always_ff @(posedge mclk) begin
        if (rst) sinceRev_r <= 4'hf;
        else if (revMark) sinceRev_r <= 4'h0;
        else if (sinceRev_r != 4'hf) sinceRev_r <= sinceRev_r + 4'h1;
    end

    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> cmdLine == '0 && status == '0) else $error("busy in reset");
    a_tick_step: assert property ($changed(status.tick) |->
        status.tick == $past(status.tick) + 7'h01 ||
        (status.tick == 7'h00 && $past(status.tick) == 7'h43) ||
        (status.tick == 7'h00 && sinceRev_r <= 4'hc))
        else $error("tick count skipped");
    a_tick_hold: assert property ($changed(status.tick) |=>
        $stable(status.tick) [*5]) else $error("tick not six cycles");
    a_intime_flag: assert property (
        sinceRst_r >= 4'(`PTS_TICK_CYC) |->
        status.inTime == (status.tick < 7'h0a))
        else $error("in-time flag wrong");
    a_coinc_seen: assert property (hit |-> ##[1:14] status.coinc)
        else $error("coincidence missed");
    a_coinc_cause: assert property ($rose(status.coinc) |->
        sinceHit_r <= 5'h0c) else $error("coincidence without hit");
    a_no_spurious: assert property (|start |->
        sinceCoinc_r <= 6'h2f) else $error("command without coincidence");
    for (genvar i = 0; i < NL; i++) begin : g_line
        // spacing counter per plane
        always_ff @(posedge mclk) begin
            if (rst) gap_r[i] <= 6'h3f;
            else if (start[i]) gap_r[i] <= 6'h00;
            else if (gap_r[i] != 6'h3f) gap_r[i] <= gap_r[i] + 6'h01;
        end
        a_cmd_pattern: assert property (start[i] |=> cmdLine[i] [*2]
            ##1 !cmdLine[i] ##1 cmdLine[i] ##1 !cmdLine[i])
            else $error("bad command pattern");
        a_cmd_spacing: assert property (start[i] |->
            gap_r[i] >= 6'h29) else $error("commands too close");
    end
    for (genvar s = 0; s < NSTACK; s++) begin : g_stack
        a_stack_stagger: assert property (
            $onehot0(start[s*NPLANE +: NPLANE])) else $error("planes together");
    end
    c_cmd_sent: cover property (|start);
    c_in_time: cover property (status.inTime ##1 status.coinc ##[1:40] |start);
    c_both_stacks: cover property (start[0] && start[NPLANE]);
endmodule

bind pts_trigger_sequencer pts_trigger_sequencer_chk #(
    .NSTACK(NSTACK), .NPLANE(NPLANE)
) chk_u (.mclk(mclk), .rst(rst), .scintIn(scintIn), .revMark(revMark),
    .cmdLine(cmdLine), .status(status));

// File: verif/pts_trigger_sequencer_tb_top.sv
// self-checking bench for the pixel trigger sequencer
`timescale 1ns/1ps
module pts_trigger_sequencer_tb_top
    import pts_pkg::*;
();
    localparam int NL = 8;       // two stacks of four planes
    logic          mclk = 1'b0;  // 250 MHz clock
    logic          rst;          // sync reset
    pts_scint_t    scintIn;      // counter stimulus
    logic          revMark;      // marker pin, pulsed once at the end
    logic [NL-1:0] cmdLine;      // trigger lines
    pts_stat_t     status;       // tick status
    int            cmdCnt [NL];  // commands seen per chip
    int            base [NL];    // counts before a trial
    int            errCnt;       // chip timing faults
    int            nMismatch = 0;
    int            checked = 0;
    int            bunch = 0;    // bench bunch index, 0..9
    logic [6:0]    lastTick;     // tick one cycle back
    logic [31:0]   seed = 32'h9ee3e631;

    pts_trigger_sequencer dut_u (.mclk(mclk), .rst(rst), .scintIn(scintIn),
        .revMark(revMark), .cmdLine(cmdLine), .status(status));
    pts_chip_model #(.NL(NL)) chip_u (.mclk(mclk), .rst(rst),
        .cmdLine(cmdLine), .cmdCnt(cmdCnt), .errCnt(errCnt));

    initial begin
        forever #2 mclk = ~mclk;
    end
    // own prescale model: period count, first after reset is bunch 0
    always @(posedge mclk) begin
        if (rst) bunch <= 0;
        else if (lastTick == 7'h43 && status.tick == 7'h00)
            bunch <= (bunch + 1) % 10;
        lastTick <= status.tick;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // twelve cycles of reset; outputs must read zero at its end
    task automatic do_reset;
        rst = 1'b1;
        repeat (12) @(negedge mclk);
        compare({cmdLine, status}, '0);
        rst = 1'b0;
    endtask
    // one random counter pattern at a chosen tick, then count commands
    task automatic trial(input bit inT, input bit f0);
        logic [6:0] tgt;
        pts_scint_t pat;
        bit         want;
        seed = xs(seed);
        pat = seed[5:0];
        // ticks kept clear of region edges, status may lag a tick
        tgt = inT ? 7'(3 + seed[9:8]) : 7'(15 + seed[15:10] % 40);
        for (int k = 0; k < 5000; k++)
            if (status.tick !== tgt || (f0 && bunch != 0)) @(negedge mclk);
        want = $countones(pat.up) >= 2 && $countones(pat.dn) >= 2;
        want = want && (!inT || bunch == 0);
        base = cmdCnt;
        scintIn = pat;
        repeat (3) @(negedge mclk);
        scintIn = '0;
        repeat (84) @(negedge mclk);
        for (int i = 0; i < NL; i++)
            compare(cmdCnt[i] - base[i], want);
    endtask

    // main sequence; a reset in mid-run restarts the prescale
    initial begin
        scintIn = '0;
        revMark = 1'b0;
        do_reset;
        for (int i = 0; i < 32; i++) begin
            if (i == 16) do_reset;
            trial(i % 4 == 0 || seed[20], i % 4 == 0);
        end
        // marker pulse at tick 30: the count restarts from zero
        for (int k = 0; k < 500; k++)
            if (status.tick !== 7'h1e) @(negedge mclk);
        revMark = 1'b1;
        repeat (2) @(negedge mclk);
        revMark = 1'b0;
        repeat (9) @(negedge mclk);
        compare(status.tick, 7'h00);
        compare(errCnt, 0);
        wrap_up;
    end
    // hang guard, well beyond the longest bunch-zero waits
    initial begin
        repeat (90000) @(posedge mclk);
        nMismatch++;
        wrap_up;
    end
endmodule
